// File: core/acsm_top.sv
// slot mapper for channels 3 to 5 of the audio serial port, apb slave
// assumes bit clock and frame sync come from the host on link_bclk
// and link_fsync, and presetn releases while pclk runs
`timescale 1ns/1ps
`default_nettype none
`include "acsm_defs.svh"

module acsm_top
  import acsm_pkg::*;
#(
  parameter int SAMPLE_W = 16
) (
  input wire logic pclk, // apb clock
  input wire logic presetn, // async reset, low active
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic link_bclk, // serial bit clock
  input wire logic link_fsync, // frame sync pin
  output logic primary_serial_out, // primary data line
  output logic primary_out_en, // primary line driven
  output logic general_pin_one, // secondary data line
  output logic general_pin_one_en // secondary line driven
);

  localparam int NCH = 3;
  localparam int SB = $clog2(SAMPLE_W);
  localparam int CW = 6 + SB;
  localparam logic [NCH-1:0][7:0] CH_RST = {`ACSM_RST_CH5, `ACSM_RST_CH4, `ACSM_RST_CH3};

  // ==========================================================
  // helpers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  // lowest channel wins a shared slot; returns {enable, bit}
  function automatic logic [1:0] pick(input logic [NCH-1:0] hit, input logic [NCH-1:0] bits);
    logic [1:0] r;
    r = 2'b00;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (hit[i]) begin
        r = {1'b1, bits[i]};
      end
    end
    return r;
  endfunction

  // ==========================================================
  // apb decode
  acsm_chcfg_t [NCH-1:0] ch_cfg_ff;
  acsm_chcfg_t [NCH-1:0] nxt_ch_cfg;
  logic [NCH-1:0][SAMPLE_W-1:0] smp_ff;
  logic [NCH-1:0][SAMPLE_W-1:0] nxt_smp;
  acsm_fmt_t fmt_ff;
  acsm_fmt_t nxt_fmt;
  acsm_apb_rsp_t rsp_ff;
  acsm_apb_rsp_t nxt_rsp;
  logic pend_ff;
  logic req_ff;
  logic ack_s1_ff;
  logic ack_s2_ff;
  logic seen_s1_ff;
  logic seen_s2_ff;

  wire [5:0] ridx = paddr[7:2];
  wire setup = psel & ~penable;
  wire wr_now = psel & penable & rsp_ff.ready & pwrite & ~rsp_ff.slverr;
  wire [NCH-1:0] hit_ch;
  wire [NCH-1:0] hit_smp;
  wire hit_fmt = ridx == `ACSM_IDX_FMT;
  wire hit_sts = ridx == `ACSM_IDX_STS;
  wire mapped = (|hit_ch | |hit_smp | hit_fmt | hit_sts) & (paddr[1:0] == 2'b00);
  wire [NCH-1:0][31:0] ch_word;
  wire [NCH-1:0][31:0] smp_word;
  wire [31:0] fmt_word = {30'h0, fmt_ff};
  wire busy = pend_ff | (req_ff != ack_s2_ff);
  wire [31:0] sts_word = {30'h0, seen_s2_ff, busy};
  wire [31:0] fmt_merged = merge(fmt_word, pwdata, pstrb);
  wire fmt_legal = fmt_merged[1:0] != 2'h3;
  wire launch = pend_ff & (req_ff == ack_s2_ff);
  wire wr_any = wr_now & (|hit_ch | |hit_smp | hit_fmt);

  genvar gc;
  generate
    for (gc = 0; gc < NCH; gc++) begin : g_reg
      wire [31:0] ch_m;
      wire [31:0] smp_m;
      assign hit_ch[gc] = ridx == 6'(`ACSM_IDX_CH3 + gc);
      assign hit_smp[gc] = ridx == 6'(`ACSM_IDX_SMP3 + gc);
      assign ch_word[gc] = {24'h0, 1'b0, ch_cfg_ff[gc]};
      assign smp_word[gc] = 32'(smp_ff[gc]);
      assign ch_m = merge(ch_word[gc], pwdata, pstrb);
      assign smp_m = merge(smp_word[gc], pwdata, pstrb);
      // bit 7 of the merged word is dropped
      assign nxt_ch_cfg[gc] = (wr_now & hit_ch[gc]) ? ch_m[6:0] : ch_cfg_ff[gc];
      assign nxt_smp[gc] = (wr_now & hit_smp[gc]) ? smp_m[SAMPLE_W-1:0] : smp_ff[gc];
    end
  endgenerate

  assign nxt_fmt = (wr_now & hit_fmt & fmt_legal) ? acsm_fmt_t'(fmt_merged[1:0]) : fmt_ff;

  // read data is picked in the setup cycle and held through access
  wire [31:0] rd_word;
  wire [NCH-1:0][31:0] rd_part;
  generate
    for (gc = 0; gc < NCH; gc++) begin : g_rd
      assign rd_part[gc] = ({32{hit_ch[gc]}} & ch_word[gc]) | ({32{hit_smp[gc]}} & smp_word[gc]);
    end
  endgenerate
  assign rd_word = rd_part[0] | rd_part[1] | rd_part[2] | ({32{hit_fmt}} & fmt_word)
                 | ({32{hit_sts}} & sts_word);

  assign nxt_rsp.ready = setup;
  assign nxt_rsp.slverr = setup & ~mapped;
  assign nxt_rsp.rdata = (setup & ~pwrite & mapped) ? rd_word : 32'h0;

  // ==========================================================
  // apb registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff <= nxt_rsp;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        ch_cfg_ff[i] <= CH_RST[i][6:0];
        smp_ff[i] <= SAMPLE_W'(`ACSM_RST_SMP);
      end
      fmt_ff <= acsm_fmt_t'(`ACSM_RST_FMT);
    end else begin
      ch_cfg_ff <= nxt_ch_cfg;
      smp_ff <= nxt_smp;
      fmt_ff <= nxt_fmt;
    end
  end

  assign prdata = rsp_ff.rdata;
  assign pready = rsp_ff.ready;
  assign pslverr = rsp_ff.slverr;

  // ==========================================================
  // settings crossing, toggle request and acknowledge
  acsm_chcfg_t [NCH-1:0] hold_cfg_ff;
  logic [NCH-1:0][SAMPLE_W-1:0] hold_smp_ff;
  acsm_fmt_t hold_fmt_ff;
  logic ack_ff;

  // a write in the launch cycle keeps pend set
  wire nxt_pend = wr_any | (pend_ff & ~launch);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ff <= 1'b0;
      req_ff <= 1'b0;
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
      seen_s1_ff <= 1'b0;
      seen_s2_ff <= 1'b0;
    end else begin
      pend_ff <= nxt_pend;
      req_ff <= req_ff ^ launch;
      ack_s1_ff <= ack_ff;
      ack_s2_ff <= ack_s1_ff;
      seen_s1_ff <= lk_seen_ff;
      seen_s2_ff <= seen_s1_ff;
    end
  end

  // holding bus stays still until the acknowledge returns
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        hold_cfg_ff[i] <= CH_RST[i][6:0];
        hold_smp_ff[i] <= SAMPLE_W'(`ACSM_RST_SMP);
      end
      hold_fmt_ff <= acsm_fmt_t'(`ACSM_RST_FMT);
    end else if (launch) begin
      hold_cfg_ff <= ch_cfg_ff;
      hold_smp_ff <= smp_ff;
      hold_fmt_ff <= fmt_ff;
    end
  end

  // ==========================================================
  // link domain reset, async assert and synced release
  logic lrst_s1_ff;
  logic lrst_s2_ff;

  always_ff @(posedge link_bclk or negedge presetn) begin
    if (!presetn) begin
      lrst_s1_ff <= 1'b0;
      lrst_s2_ff <= 1'b0;
    end else begin
      lrst_s1_ff <= 1'b1;
      lrst_s2_ff <= lrst_s1_ff;
    end
  end

  wire link_rstn = lrst_s2_ff;

  // ==========================================================
  // link domain settings and frame sync
  acsm_chcfg_t [NCH-1:0] lk_cfg_ff;
  logic [NCH-1:0][SAMPLE_W-1:0] lk_smp_ff;
  acsm_fmt_t lk_fmt_ff;
  logic req_s1_ff;
  logic req_s2_ff;
  logic fs_s1_ff;
  logic fs_s2_ff;
  logic fs_prev_ff;
  logic lag_ff;
  logic lk_seen_ff;
  logic right_ff;
  logic [CW-1:0] cnt_ff;
  logic pri_ff;
  logic pri_en_ff;
  logic sec_ff;
  logic sec_en_ff;

  wire take = req_s2_ff != ack_ff;

  always_ff @(posedge link_bclk or negedge link_rstn) begin
    if (!link_rstn) begin
      req_s1_ff <= 1'b0;
      req_s2_ff <= 1'b0;
      ack_ff <= 1'b0;
      fs_s1_ff <= 1'b0;
      fs_s2_ff <= 1'b0;
      fs_prev_ff <= 1'b0;
    end else begin
      req_s1_ff <= req_ff;
      req_s2_ff <= req_s1_ff;
      ack_ff <= req_s2_ff;
      fs_s1_ff <= link_fsync;
      fs_s2_ff <= fs_s1_ff;
      fs_prev_ff <= fs_s2_ff;
    end
  end

  always_ff @(posedge link_bclk or negedge link_rstn) begin
    if (!link_rstn) begin
      for (int i = 0; i < NCH; i++) begin
        lk_cfg_ff[i] <= CH_RST[i][6:0];
        lk_smp_ff[i] <= SAMPLE_W'(`ACSM_RST_SMP);
      end
      lk_fmt_ff <= acsm_fmt_t'(`ACSM_RST_FMT);
    end else if (take) begin
      lk_cfg_ff <= hold_cfg_ff;
      lk_smp_ff <= hold_smp_ff;
      lk_fmt_ff <= hold_fmt_ff;
    end
  end

  // ==========================================================
  // frame position
  wire is_tdm = lk_fmt_ff == ACSM_FMT_TDM;
  wire is_i2s = lk_fmt_ff == ACSM_FMT_I2S;
  wire fs_rise = fs_s2_ff & ~fs_prev_ff;
  wire fs_edge = fs_s2_ff ^ fs_prev_ff;
  // tdm frames start on the rising edge, half frames on either edge
  // i2s restarts one bit late, so the last bit of the old half still goes out
  wire start = is_tdm ? fs_rise : (is_i2s ? lag_ff : fs_edge);
  wire [CW-1:0] pos = start ? {CW{1'b0}} : CW'(cnt_ff + 1'b1);
  wire nxt_right = start ? (is_i2s ? fs_s2_ff : ~fs_s2_ff) : right_ff;
  wire nxt_seen = lk_seen_ff | start;
  wire [5:0] eff_slot = is_tdm ? pos[CW-1:SB] : {nxt_right, pos[CW-2:SB]};
  wire slot_ok = nxt_seen & (is_tdm | ~pos[CW-1]);
  wire [SB-1:0] bit_idx = pos[SB-1:0];

  wire [NCH-1:0] hit_pri;
  wire [NCH-1:0] hit_sec;
  wire [NCH-1:0] data_bit;
  generate
    for (gc = 0; gc < NCH; gc++) begin : g_map
      wire hit = slot_ok & (lk_cfg_ff[gc].slot_num == eff_slot);
      assign hit_pri[gc] = hit & ~lk_cfg_ff[gc].line_sel;
      assign hit_sec[gc] = hit & lk_cfg_ff[gc].line_sel;
      // msb first
      assign data_bit[gc] = lk_smp_ff[gc][~bit_idx];
    end
  endgenerate

  wire [1:0] pri_pick = pick(hit_pri, data_bit);
  wire [1:0] sec_pick = pick(hit_sec, data_bit);

  always_ff @(posedge link_bclk or negedge link_rstn) begin
    if (!link_rstn) begin
      cnt_ff <= '0;
      right_ff <= 1'b0;
      lk_seen_ff <= 1'b0;
      lag_ff <= 1'b0;
    end else begin
      cnt_ff <= pos;
      lag_ff <= fs_edge;
      right_ff <= nxt_right;
      lk_seen_ff <= nxt_seen;
    end
  end

  always_ff @(posedge link_bclk or negedge link_rstn) begin
    if (!link_rstn) begin
      pri_ff <= 1'b0;
      pri_en_ff <= 1'b0;
      sec_ff <= 1'b0;
      sec_en_ff <= 1'b0;
    end else begin
      pri_en_ff <= pri_pick[1];
      pri_ff <= pri_pick[0];
      sec_en_ff <= sec_pick[1];
      sec_ff <= sec_pick[0];
    end
  end

  assign primary_serial_out = pri_ff;
  assign primary_out_en = pri_en_ff;
  assign general_pin_one = sec_ff;
  assign general_pin_one_en = sec_en_ff;

endmodule
`default_nettype wire

// File: core/acsm_defs.svh
// register indices, field positions and reset values of the slot mapper
// assumes inclusion by bare name from the package and the top module
`ifndef ACSM_DEFS_SVH
`define ACSM_DEFS_SVH

// register indices; byte address is four times the index
`define ACSM_IDX_CH3 6'h0d
`define ACSM_IDX_CH4 6'h0e
`define ACSM_IDX_CH5 6'h0f
`define ACSM_IDX_FMT 6'h20
`define ACSM_IDX_SMP3 6'h21
`define ACSM_IDX_STS 6'h24

// channel register fields
`define ACSM_RSVD_BIT 7
`define ACSM_LSEL_BIT 6
`define ACSM_SLOT_MSB 5

// reset values
`define ACSM_RST_CH3 8'h02
`define ACSM_RST_CH4 8'h03
`define ACSM_RST_CH5 8'h04
`define ACSM_RST_FMT 2'h0
`define ACSM_RST_SMP 32'h00000000

`endif

// File: core/acsm_pkg.sv
// types shared by the slot mapper
// assumes nothing beyond the constants header
`include "acsm_defs.svh"

package acsm_pkg;

  // serial frame format
  typedef enum logic [1:0] {
    ACSM_FMT_TDM = 2'h0,
    ACSM_FMT_I2S = 2'h1,
    ACSM_FMT_LJ = 2'h2
  } acsm_fmt_t;

  // stored channel configuration, reserved bit not kept
  typedef struct packed {
    logic line_sel;
    logic [5:0] slot_num;
  } acsm_chcfg_t;

  // apb answer carried as one group
  typedef struct packed {
    logic ready;
    logic slverr;
    logic [31:0] rdata;
  } acsm_apb_rsp_t;

endpackage

// File: tb/acsm_top_props.sv
// port assertions for the slot mapper
// assumes a bind onto acsm_top
`timescale 1ns/1ps
`default_nettype none
module acsm_top_props #(
  parameter int SAMPLE_W = 16
) (
  input wire logic pclk, // apb clock
  input wire logic presetn, // reset, low
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic [7:0] paddr, // address
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic link_bclk, // link clock
  input wire logic primary_serial_out, // primary data
  input wire logic primary_out_en, // primary owned
  input wire logic general_pin_one, // second data
  input wire logic general_pin_one_en // second owned
);
  // ====================
  // apb answer and link idle levels
  AST_READY_NEXT: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready) else $error("no ready after setup");
  AST_READY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready) else $error("ready held too long");
  AST_ERR_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && paddr == 8'hfc |=> pready && pslverr) else $error("no error");
  AST_CH_BIT7: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && paddr inside {8'h34, 8'h38, 8'h3c} |=> !pslverr && prdata[31:7] == 25'h0)
    else $error("channel word bad");
  AST_RDATA_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h0) else $error("read data outside access");
  AST_ERR_READY: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready) else $error("error without ready");
  AST_PRI_QUIET: assert property (@(posedge link_bclk) disable iff (!presetn)
    !primary_out_en |-> !primary_serial_out) else $error("primary data while idle");
  AST_SEC_QUIET: assert property (@(posedge link_bclk) disable iff (!presetn)
    !general_pin_one_en |-> !general_pin_one) else $error("second data while idle");
endmodule

bind acsm_top acsm_top_props #(.SAMPLE_W(SAMPLE_W)) u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .link_bclk(link_bclk), .primary_serial_out(primary_serial_out),
  .primary_out_en(primary_out_en), .general_pin_one(general_pin_one),
  .general_pin_one_en(general_pin_one_en));
`default_nettype wire

// File: tb/acsm_host.sv
// host model: makes bit clock and frame sync, records both data lines
// assumes 16-bit slots and 64-slot frames
`timescale 1ns/1ps
`default_nettype none
module acsm_host (
  output logic bclk, // link bit clock
  output logic fsync, // frame sync
  input wire logic pri, // primary data
  input wire logic pri_en, // primary owned
  input wire logic sec, // second data
  input wire logic sec_en // second owned
);
  // ====================
  // clock only while asked, captured bits by frame position
  logic [0:1023] pe, pd, se, sd;
  initial begin
    bclk = 0;
    fsync = 0;
  end
  task automatic pulses(input int n);
    #7;
    repeat (n) begin
      bclk = 1;
      #40;
      bclk = 0;
      #40;
    end
  endtask
  // tdm: one-bit sync pulse; i2s: left while low; lj: left while high
  task automatic frame(input logic [1:0] fmt);
    int d;
    logic lvl;
    d = (fmt == 2'h1) ? 4 : 3;
    lvl = fmt == 2'h1;
    fsync = lvl;
    pulses(8);
    fsync = !lvl;
    for (int r = 1; r < 1024 + d; r++) begin
      bclk = 1;
      #40;
      if (r >= d) {pe[r-d], pd[r-d], se[r-d], sd[r-d]} = {pri_en, pri, sec_en, sec};
      bclk = 0;
      if (r == ((fmt == 2'h0) ? 1 : 512)) fsync = lvl;
      #40;
    end
  endtask
endmodule
`default_nettype wire

// File: tb/tb_acsm_top.sv
// self-checking bench for the slot mapper
// assumes acsm_host on the link side and apb zero wait states
`timescale 1ns/1ps
`default_nettype none
module tb_acsm_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, bclk, fsync, pri, pri_en, sec, sec_en;
  logic [15:0] smp [3] = '{16'ha5c3, 16'h3c5a, 16'h8001};
  int miscompares = 0, cmp_count = 0, cyc = 0;
  always #20 pclk = ~pclk;
  acsm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_bclk(bclk), .link_fsync(fsync),
    .primary_serial_out(pri), .primary_out_en(pri_en), .general_pin_one(sec),
    .general_pin_one_en(sec_en));
  acsm_host host (.bclk(bclk), .fsync(fsync), .pri(pri), .pri_en(pri_en), .sec(sec),
    .sec_en(sec_en));
  // ====================
  // shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic err);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    check({31'h0, pslverr}, {31'h0, err});
    psel <= 0;
    penable <= 0;
  endtask
  // lowest channel wins a shared slot; field value n is slot n of the frame
  task automatic run_frame(input logic [6:0] c3, c4, c5, input logic [1:0] fmt);
    logic [6:0] cf [3];
    logic [3:0] ex;
    cf = '{c3, c4, c5};
    host.frame(fmt);
    for (int p = 0; p < 1024; p++) begin
      ex = 4'h0;
      for (int c = 2; c >= 0; c--) begin
        if (cf[c][5:0] == p / 16) begin
          if (cf[c][6]) ex[1:0] = {1'b1, smp[c][15 - p % 16]};
          else ex[3:2] = {1'b1, smp[c][15 - p % 16]};
        end
      end
      check({28'h0, host.pe[p], host.pd[p], host.se[p], host.sd[p]}, {28'h0, ex});
    end
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ====================
  // scenarios
  task automatic test_reset();
    for (int i = 0; i < 3; i++) begin
      apb(1, 8'h84 + 8'(4 * i), {16'h0, smp[i]}, 0);
      apb(0, 8'h34 + 8'(4 * i), 32'h0, 0);
      check(rd, 32'h2 + 32'(i));
    end
    apb(0, 8'hfc, 32'h0, 1);
    apb(1, 8'h35, 32'h7f, 1);
    apb(0, 8'h34, 32'h0, 0);
    check(rd, 32'h2);
    run_frame(7'h02, 7'h03, 7'h04, 2'h0);
    $display("test reset done");
  endtask
  task automatic test_tdm();
    apb(1, 8'h34, 32'h40, 0);
    apb(1, 8'h38, 32'h40, 0);
    apb(1, 8'h3c, 32'h3f, 0);
    apb(0, 8'h34, 32'h0, 0);
    check(rd, 32'h40);
    run_frame(7'h40, 7'h40, 7'h3f, 2'h0);
    $display("test tdm done");
  endtask
  task automatic test_i2s();
    apb(1, 8'h80, 32'h1, 0);
    apb(1, 8'h34, 32'h20, 0);
    apb(1, 8'h38, 32'h1f, 0);
    apb(1, 8'h3c, 32'h7f, 0);
    run_frame(7'h20, 7'h1f, 7'h7f, 2'h1);
    $display("test i2s done");
  endtask
  task automatic test_lj();
    apb(1, 8'h80, 32'h2, 0);
    apb(1, 8'h80, 32'h3, 0);
    apb(0, 8'h80, 32'h0, 0);
    check(rd, 32'h2);
    apb(1, 8'h34, 32'h3f, 0);
    apb(1, 8'h38, 32'h00, 0);
    apb(1, 8'h3c, 32'h61, 0);
    apb(0, 8'h90, 32'h0, 0);
    check(rd, 32'h3);
    run_frame(7'h3f, 7'h00, 7'h61, 2'h2);
    apb(0, 8'h90, 32'h0, 0);
    check(rd, 32'h2);
    $display("test lj done");
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    fork
      host.pulses(4);
    join_none
    repeat (3) @(posedge pclk);
    presetn <= 1;
    test_reset();
    test_tdm();
    test_i2s();
    test_lj();
    results();
  end
endmodule
`default_nettype wire
